// >>> hdl/sac_spi_audio.sv
// Audio serial port: register slave, link shifter, error events and interrupt.
//
// Implementation choices: strobed register access and the placing of the registers.
`include "sac_defines.svh"

module sac_spi_audio import sac_pkg::*; (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset,
  input  wire logic [`SAC_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [31:0]           o_rdata,
  output logic                       o_irq,
  input  wire logic                  i_sck,
  input  wire logic                  i_ws,
  input  wire logic                  i_sdi,
  output logic                       o_sdo,
  output logic                       o_sdo_oe
);
  sac_link_t              link_raw;
  sac_link_t              link;
  sac_slot_t              slot;
  sac_fmt_t               fmt;
  sac_state_t             state;
  sac_state_t             next_state;
  logic                   ctrl_on;
  logic [31:0]            ctrl2;
  logic [`SAC_STAT_W-1:0] stat;
  logic [`SAC_STAT_W-1:0] mask;
  logic [`SAC_STAT_W-1:0] stat_set;
  logic [`SAC_MSB:0]      tx_buf;
  logic [`SAC_MSB:0]      tx_shift;
  logic [`SAC_MSB:0]      tx_repeat;
  logic [`SAC_MSB:0]      tx_load;
  logic [`SAC_MSB:0]      rx_buf;
  logic [`SAC_MSB:0]      rx_shift;
  logic [`SAC_MSB:0]      rx_word;
  logic                   tx_full;
  logic                   rx_full;
  logic                   sck_prev;
  logic                   run;
  logic                   audio;
  logic                   mono;
  logic                   bit_take;
  logic                   word_done;
  logic                   tx_pop;
  logic                   rx_accept;
  logic                   rx_ovf;
  logic                   tx_und;
  logic                   frm_err;
  logic                   err_evt;
  logic                   wr_ctrl;
  logic                   wr_ctrl2;
  logic                   wr_stat;
  logic                   wr_mask;
  logic                   wr_txb;
  logic                   rd_rxb;
  logic [31:0]            rd_value;

  assign link_raw = '{sck: i_sck, ws: i_ws, sdi: i_sdi};

  sac_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   (link_raw),
    .o_sync    (link)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= link.sck;
    end
  end

  assign run = state == st_run;

  assign audio = ctrl2[`SAC_B_AUD_EN];
  assign fmt  = audio ? sac_fmt_t'({1'b0, ctrl2[`SAC_B_PROT_HI:`SAC_B_PROT_LO]}) : fmt_spi;
  assign mono = audio & ctrl2[`SAC_B_MONO];

  sac_slot_timer u_slot (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_run     (run),
    .i_rise    (link.sck & ~sck_prev),
    .i_ws      (link.ws),
    .i_fmt     (fmt),
    .o_slot    (slot)
  );

  assign bit_take  = slot.window;
  assign word_done = bit_take & slot.word_end;
  assign tx_pop    = word_done & ~(mono & ~slot.right);
  assign rx_word   = {rx_shift[`SAC_MSB-1:0], link.sdi};
  // A read in the same cycle frees the holding register, so the word is kept.
  assign rx_accept = word_done & (~rx_full | rd_rxb);
  assign rx_ovf    = word_done & rx_full & ~rd_rxb;
  assign tx_und    = tx_pop & ~tx_full;
  assign frm_err   = slot.frame_err;

  always_comb begin
    err_evt = 1'b0;
    if (frm_err && ctrl2[`SAC_B_FRM_EN]) begin
      err_evt = 1'b1;
    end
    if (rx_ovf && ctrl2[`SAC_B_RXOVF_EN]) begin
      err_evt = 1'b1;
    end
    if (tx_und && ctrl2[`SAC_B_TXUND_EN]) begin
      err_evt = 1'b1;
    end
  end

  always_comb begin
    stat_set                = '0;
    stat_set[`SAC_S_RXOVF] = rx_ovf;
    stat_set[`SAC_S_TXUND] = tx_und;
    stat_set[`SAC_S_FRM]   = frm_err;
    stat_set[`SAC_S_ERR]   = err_evt;
    stat_set[`SAC_S_RXRDY] = rx_accept;
  end

  assign wr_ctrl  = i_wr & (i_addr == `SAC_OFS_CTRL);
  assign wr_ctrl2 = i_wr & (i_addr == `SAC_OFS_CTRL2);
  assign wr_stat  = i_wr & (i_addr == `SAC_OFS_STAT);
  assign wr_mask  = i_wr & (i_addr == `SAC_OFS_MASK);
  assign wr_txb   = i_wr & (i_addr == `SAC_OFS_TXB);
  assign rd_rxb   = i_rd & (i_addr == `SAC_OFS_RXB);

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (ctrl_on) begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (!ctrl_on) begin
          next_state = st_idle;
        end else if (rx_ovf && !ctrl2[`SAC_B_IGN_RXOVF]) begin
          next_state = st_halt;
        end else if (tx_und && !ctrl2[`SAC_B_IGN_TXUND]) begin
          next_state = st_halt;
        end
      end
      st_halt: begin
        if (!ctrl_on) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl_on <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_on <= i_wdata[`SAC_B_ON];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl2 <= `SAC_RST_WORD;
    end else if (wr_ctrl2) begin
      if (ctrl_on) begin
        ctrl2 <= (i_wdata & `SAC_CTRL2_WMASK & ~`SAC_CTRL2_LOCK)
                 | (ctrl2 & `SAC_CTRL2_LOCK);
      end else begin
        ctrl2 <= i_wdata & `SAC_CTRL2_WMASK;
      end
    end
  end

  // Hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~(wr_stat ? i_wdata[`SAC_STAT_W-1:0] : '0)) | stat_set;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= i_wdata[`SAC_STAT_W-1:0];
    end
  end

  assign o_irq = |(stat & mask);

  // A write in the cycle of a pop refills the buffer rather than losing the word.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tx_full <= 1'b0;
      tx_buf  <= '0;
    end else begin
      if (tx_pop) begin
        tx_full <= 1'b0;
      end
      if (wr_txb) begin
        tx_full <= 1'b1;
        tx_buf  <= i_wdata[`SAC_MSB:0];
      end
    end
  end

  assign tx_load = tx_pop ? (tx_full ? tx_buf : '0) : tx_repeat;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !run) begin
      tx_shift <= '0;
    end else if (word_done) begin
      tx_shift <= tx_load;
    end else if (bit_take) begin
      tx_shift <= {tx_shift[`SAC_MSB-1:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tx_repeat <= '0;
    end else if (tx_pop) begin
      tx_repeat <= tx_load;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rx_shift <= '0;
    end else if (bit_take) begin
      rx_shift <= rx_word;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rx_full <= 1'b0;
      rx_buf  <= '0;
    end else if (rx_accept) begin
      rx_full <= 1'b1;
      rx_buf  <= rx_word;
    end else if (rd_rxb) begin
      rx_full <= 1'b0;
    end
  end

  // The data line is released outside a serial select so several devices can share it.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdo    <= run & tx_shift[`SAC_MSB];
      o_sdo_oe <= run & (audio | ~link.ws);
    end
  end

  always_comb begin
    case (i_addr)
      `SAC_OFS_CTRL:  rd_value = 32'(ctrl_on) << `SAC_B_ON;
      `SAC_OFS_CTRL2: rd_value = ctrl2;
      `SAC_OFS_STAT:  rd_value = 32'(stat) | (32'(rx_full) << `SAC_S_RXFULL)
                                 | (32'(tx_full) << `SAC_S_TXFULL)
                                 | (32'(state == st_halt) << `SAC_S_HALT);
      `SAC_OFS_MASK:  rd_value = 32'(mask);
      `SAC_OFS_RXB:   rd_value = ctrl2[`SAC_B_RX_SEXT] ? sac_sext(rx_buf) : 32'(rx_buf);
      default:        rd_value = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_value : '0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sext_on_a:
    assert property (rd_rxb && ctrl2[`SAC_B_RX_SEXT]
                     |=> o_rdata[31:16] == {16{o_rdata[15]}})
      else $error("received word not sign extended");
  sext_off_a:
    assert property (rd_rxb && !ctrl2[`SAC_B_RX_SEXT] |=> o_rdata[31:16] == 16'h0000)
      else $error("received word extended while disabled");
  frame_event_a:
    assert property (frm_err && ctrl2[`SAC_B_FRM_EN] |=> stat[`SAC_S_ERR])
      else $error("enabled frame error raised no event");
  rx_event_a:
    assert property (rx_ovf && ctrl2[`SAC_B_RXOVF_EN] |=> stat[`SAC_S_ERR])
      else $error("enabled overflow raised no event");
  tx_event_a:
    assert property (tx_und && ctrl2[`SAC_B_TXUND_EN] |=> stat[`SAC_S_ERR])
      else $error("enabled underrun raised no event");
  rx_keep_a:
    assert property (rx_ovf && ctrl2[`SAC_B_IGN_RXOVF] && !wr_ctrl && !tx_und
                     |=> $stable(rx_buf) && state == st_run)
      else $error("ignored overflow changed data or stopped");
  rx_halt_a:
    assert property (rx_ovf && !ctrl2[`SAC_B_IGN_RXOVF] && !wr_ctrl
                     |=> state == st_halt ##1 !slot.strobe)
      else $error("critical overflow did not stop the port");
  tx_zero_a:
    assert property (tx_und && ctrl2[`SAC_B_IGN_TXUND] |=> tx_shift == 16'h0000)
      else $error("ignored underrun did not send zeros");
  tx_halt_a:
    assert property (tx_und && !ctrl2[`SAC_B_IGN_TXUND] && !rx_ovf && !wr_ctrl
                     |=> state == st_halt)
      else $error("critical underrun did not stop the port");
  mono_repeat_a:
    assert property (word_done && mono && !slot.right && run && ctrl_on && !wr_ctrl
                     |=> tx_shift == $past(tx_repeat) && $stable(tx_full))
      else $error("mono right slot did not repeat the word");
  audio_lock_a:
    assert property (wr_ctrl2 && ctrl_on
                     |=> (ctrl2 & `SAC_CTRL2_LOCK) == ($past(ctrl2) & `SAC_CTRL2_LOCK))
      else $error("audio fields changed while enabled");
  err_cause_a:
    assert property ($rose(stat[`SAC_S_ERR]) |-> $past(err_evt))
      else $error("error event without an enabled cause");
endmodule : sac_spi_audio

// >>> hdl/sac_defines.svh
// Register map, field positions, reset values and link timing for the audio port.
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_ADDR_W      8
`define SAC_OFS_CTRL    8'h00
`define SAC_OFS_CTRL2   8'h04
`define SAC_OFS_STAT    8'h08
`define SAC_OFS_MASK    8'h0C
`define SAC_OFS_TXB     8'h10
`define SAC_OFS_RXB     8'h14
`define SAC_RST_WORD    32'h0000_0000
`define SAC_B_ON        15
`define SAC_B_RX_SEXT   15
`define SAC_B_FRM_EN    12
`define SAC_B_RXOVF_EN  11
`define SAC_B_TXUND_EN  10
`define SAC_B_IGN_RXOVF 9
`define SAC_B_IGN_TXUND 8
`define SAC_B_AUD_EN    7
`define SAC_B_MONO      3
`define SAC_B_PROT_HI   1
`define SAC_B_PROT_LO   0
`define SAC_CTRL2_WMASK (32'h0000_9F8B)
`define SAC_CTRL2_LOCK  (32'h0000_008B)
`define SAC_STAT_W      5
`define SAC_S_RXOVF     0
`define SAC_S_TXUND     1
`define SAC_S_FRM       2
`define SAC_S_ERR       3
`define SAC_S_RXRDY     4
`define SAC_S_RXFULL    8
`define SAC_S_TXFULL    9
`define SAC_S_HALT      10
`define SAC_WORD_W      16
`define SAC_MSB         15
`define SAC_LAST_BIT    4'hF
`define SAC_WORD_OFF    6'd16
`define SAC_POS_LEFT    6'h00
`define SAC_POS_RIGHT   6'h20
`define SAC_POS_IDLE    6'h3F
`define SAC_DLY_I2S     5'h01
`define SAC_DLY_LJ      5'h00
`define SAC_DLY_RJ      5'h10
`define SAC_DLY_PCM     5'h01
`endif

// >>> hdl/sac_pkg.sv
// Types shared by the audio port modules.
`include "sac_defines.svh"
package sac_pkg;
  typedef enum logic [2:0] {
    fmt_i2s = 3'b000,
    fmt_lj  = 3'b001,
    fmt_rj  = 3'b010,
    fmt_pcm = 3'b011,
    fmt_spi = 3'b100
  } sac_fmt_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run  = 2'b01,
    st_halt = 2'b10
  } sac_state_t;
  typedef struct packed {logic sck; logic ws; logic sdi;} sac_link_t;
  typedef struct packed {
    logic strobe; logic window; logic word_end; logic right; logic frame_err;
  } sac_slot_t;
  function automatic logic [31:0] sac_sext(input logic [`SAC_WORD_W-1:0] w);
    return {{(32-`SAC_WORD_W){w[`SAC_MSB]}}, w};
  endfunction : sac_sext
endpackage : sac_pkg

// >>> hdl/sac_sync.sv
// Three-stage synchroniser with agreement filter for the link pins.
`include "sac_defines.svh"
module sac_sync import sac_pkg::*; (
  input  wire logic      i_clk_sys,
  input  wire logic      i_reset,
  input  wire sac_link_t i_async,
  output sac_link_t      o_sync
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  // A change is taken only once the second and third stages agree.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s1     <= 3'h0;
      s2     <= 3'h0;
      s3     <= 3'h0;
      o_sync <= sac_link_t'(3'h0);
    end else begin
      s1     <= i_async;
      s2     <= s1;
      s3     <= s2;
      o_sync <= sac_link_t'((s2 & s3) | ((s2 ^ s3) & o_sync));
    end
  end
endmodule : sac_sync

// >>> hdl/sac_slot_timer.sv
// Bit position tracker: slot boundaries, data window and frame errors.
`include "sac_defines.svh"
module sac_slot_timer import sac_pkg::*; (
  input  wire logic     i_clk_sys,
  input  wire logic     i_reset,
  input  wire logic     i_run,
  input  wire logic     i_rise,
  input  wire logic     i_ws,
  input  wire sac_fmt_t i_fmt,
  output sac_slot_t     o_slot
);
  logic [5:0] pos;
  logic       ws_prev;
  logic       synced;
  logic       edge_ws;
  logic       bnd;
  logic [5:0] bpos;
  logic [5:0] npos;
  logic [4:0] dly;
  logic [5:0] off;
  logic       spi;
  assign edge_ws = i_ws != ws_prev;
  assign spi     = i_fmt == fmt_spi;
  always_comb begin
    bnd  = edge_ws;
    bpos = i_ws ? `SAC_POS_LEFT : `SAC_POS_RIGHT;
    dly  = `SAC_DLY_LJ;
    case (i_fmt)
      fmt_i2s: begin
        bpos = i_ws ? `SAC_POS_RIGHT : `SAC_POS_LEFT;
        dly  = `SAC_DLY_I2S;
      end
      fmt_lj: dly = `SAC_DLY_LJ;
      fmt_rj: dly = `SAC_DLY_RJ;
      fmt_pcm: begin
        bnd  = edge_ws & i_ws;
        bpos = `SAC_POS_LEFT;
        dly  = `SAC_DLY_PCM;
      end
      default: begin
        bnd  = i_ws;
        bpos = `SAC_POS_IDLE;
      end
    endcase
    npos = bnd ? bpos : pos + 6'h01;
    off  = {1'b0, npos[4:0]} - {1'b0, dly};
    o_slot.strobe = i_rise & i_run;
    o_slot.right  = ~spi & npos[5];
    if (spi) begin
      o_slot.window    = o_slot.strobe & ~i_ws;
      o_slot.word_end  = npos[3:0] == `SAC_LAST_BIT;
      o_slot.frame_err = o_slot.strobe & edge_ws & i_ws & synced
                         & (pos[3:0] != `SAC_LAST_BIT);
    end else begin
      o_slot.window    = o_slot.strobe & (synced | bnd) & (off < `SAC_WORD_OFF);
      o_slot.word_end  = off[3:0] == `SAC_LAST_BIT;
      o_slot.frame_err = o_slot.strobe & bnd & synced & (pos + 6'h01 != bpos);
    end
  end
  // In the serial mode the select is only seen on clock edges, so a select that
  // drops without clocking is noticed at the next edge.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pos     <= `SAC_POS_IDLE;
      ws_prev <= 1'b0;
      synced  <= 1'b0;
    end else if (!i_run) begin
      // While stopped the detector follows the line, so the first select edge after a start
      // is a real boundary and not lost against a fixed reset level.
      pos     <= `SAC_POS_IDLE;
      ws_prev <= i_ws;
      synced  <= 1'b0;
    end else if (i_rise) begin
      pos     <= npos;
      ws_prev <= i_ws;
      synced  <= spi ? ~i_ws : (synced | bnd);
    end
  end
endmodule : sac_slot_timer

// >>> verification/sac_codec_model.sv
// Behavioural audio codec that drives the link and captures the words sent back.
module sac_codec_model import sac_pkg::*; (
  output logic      o_sck,
  output logic      o_ws,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 24;
  logic [15:0] cap;
  logic        sdo_seen;
  // A released data line reads as the inverse of its last value, so stale bits cannot pass.
  assign sdo_seen = i_sdo_oe ? i_sdo : ~i_sdo;
  initial begin
    o_sck = 1'b0;
    o_ws  = 1'b1;
    o_sdi = 1'b0;
  end
  // Sends nfr frames and counts captured slot words equal to match.
  // The bit clock stands still between calls, as a real codec would between bursts.
  task automatic run(input logic [1:0] fmt, input int nfr, input logic [15:0] lw,
                     input logic [15:0] rw, input logic [15:0] match, input logic bad,
                     output int hits);
    int   ofs;
    int   b;
    logic idle;
    ofs  = (fmt == 2'b01) ? 0 : (fmt == 2'b10) ? 16 : 1;
    idle = (fmt == 2'b00);
    hits = 0;
    o_ws = idle;
    for (int f = 0; f < nfr; f++) begin
      for (int p = 0; p < 64; p++) begin
        b = (p % 32) - ofs;
        if (fmt == 2'b11) begin
          o_ws = (p == 0);
        end else begin
          o_ws = (p < 32) ? ~idle : idle;
        end
        if (bad && f == nfr - 1 && p == 8) begin
          o_ws = ~o_ws;
        end
        // Outside the data window the line toggles so stale bits cannot pass.
        if (b >= 0 && b < 16) begin
          o_sdi = (p < 32) ? lw[15 - b] : rw[15 - b];
        end else begin
          o_sdi = (p % 2 == 1);
        end
        #HALF o_sck = 1'b1;
        if (b >= 0 && b < 16) begin
          cap = {cap[14:0], sdo_seen};
        end
        if (b == 15 && cap === match) begin
          hits++;
        end
        #HALF o_sck = 1'b0;
      end
    end
  endtask : run
  // Parks the word select at the level that precedes the first boundary of a burst.
  task automatic park(input logic lvl);
    o_ws = lvl;
    #(2 * HALF);
  endtask : park
  // One serial word with the select low; returns what the port shifted back.
  task automatic xfer(input logic [15:0] w, output logic [15:0] got);
    o_ws = 1'b0;
    #HALF;
    for (int i = 0; i < 16; i++) begin
      o_sdi = w[15 - i];
      #HALF o_sck = 1'b1;
      got = {got[14:0], sdo_seen};
      #HALF o_sck = 1'b0;
    end
    o_ws = 1'b1;
    #(2 * HALF);
  endtask : xfer
endmodule : sac_codec_model

// >>> verification/sac_spi_audio_bench.sv
// Self-checking bench for the audio port: registers, framing, error events and interrupt.
`include "sac_defines.svh"
module sac_spi_audio_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 40000;
  logic                    i_clk_sys, i_reset, i_wr, i_rd, o_irq, o_sdo, o_sdo_oe;
  logic                    sck, ws, sdi;
  logic [`SAC_ADDR_W-1:0]  i_addr;
  logic [31:0]             i_wdata, o_rdata, rv;
  int                      n_fail, checked, cycles, hits;

  sac_spi_audio dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_sck(sck), .i_ws(ws), .i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe));
  sac_codec_model codec (.o_sck(sck), .o_ws(ws), .o_sdi(sdi), .i_sdo(o_sdo),
    .i_sdo_oe(o_sdo_oe));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic rdm(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    chk(what, exp, rv & m);
  endtask : rdm

  task automatic cfg(input logic [31:0] c2);
    wr(`SAC_OFS_CTRL, 32'h0000_0000);
    // The select idles high before an I2S or serial burst and low before the others.
    codec.park(~c2[7] | (c2[1:0] == 2'b00));
    wr(`SAC_OFS_STAT, 32'h0000_001F);
    rdm("flush", `SAC_OFS_RXB, 32'h0000_0000, 32'h0000_0000);
    wr(`SAC_OFS_CTRL2, c2);
    wr(`SAC_OFS_CTRL, 32'h0000_8000);
  endtask : cfg

  task automatic t_regs();
    rdm("ctrl2 reset", `SAC_OFS_CTRL2, 32'hFFFF_FFFF, `SAC_RST_WORD);
    rdm("stat reset", `SAC_OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rdm("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`SAC_OFS_CTRL2, 32'hFFFF_FFFF);
    rdm("ctrl2 open", `SAC_OFS_CTRL2, 32'hFFFF_FFFF, `SAC_CTRL2_WMASK);
    wr(`SAC_OFS_CTRL, 32'h0000_8000);
    wr(`SAC_OFS_CTRL2, 32'h0000_0000);
    rdm("ctrl2 locked", `SAC_OFS_CTRL2, 32'hFFFF_FFFF, `SAC_CTRL2_LOCK);
    wr(`SAC_OFS_CTRL, 32'h0000_0000);
    wr(`SAC_OFS_CTRL2, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  // Two frames deliver four slot words; the first word must survive the overflows.
  task automatic t_formats();
    logic [15:0] w;
    for (int f = 0; f < 4; f++) begin
      w = 16'hA5C0 | 16'(f);
      cfg(32'h0000_0380 | 32'(f));
      codec.run(2'(f), 2, w, 16'h1234, 16'h0000, 1'b0, hits);
      rdm("halt clear", `SAC_OFS_STAT, 32'h0000_0401, 32'h0000_0001);
      rdm("rx word", `SAC_OFS_RXB, 32'hFFFF_FFFF, {16'h0000, w});
    end
    $display("test formats done");
  endtask : t_formats

  task automatic t_sext();
    cfg(32'h0000_8380);
    codec.run(2'b00, 2, 16'h8A01, 16'h0F0F, 16'h0000, 1'b0, hits);
    rdm("rx sext", `SAC_OFS_RXB, 32'hFFFF_FFFF, 32'hFFFF_8A01);
    $display("test sext done");
  endtask : t_sext

  task automatic t_events();
    cfg(32'h0000_1380);
    wr(`SAC_OFS_MASK, 32'h0000_0008);
    codec.run(2'b00, 2, 16'h0101, 16'h0202, 16'h0000, 1'b1, hits);
    rdm("frame event", `SAC_OFS_STAT, 32'h0000_000C, 32'h0000_000C);
    chk("irq set", 32'h1, {31'h0, o_irq});
    wr(`SAC_OFS_MASK, 32'h0000_0000);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    wr(`SAC_OFS_MASK, 32'h0000_0008);
    wr(`SAC_OFS_STAT, 32'h0000_001F);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    cfg(32'h0000_0380);
    codec.run(2'b00, 2, 16'h0101, 16'h0202, 16'h0000, 1'b1, hits);
    rdm("no events", `SAC_OFS_STAT, 32'h0000_000F, 32'h0000_0007);
    $display("test events done");
  endtask : t_events

  task automatic t_overflow();
    cfg(32'h0000_0980);
    codec.run(2'b00, 2, 16'h0303, 16'h0404, 16'h0000, 1'b0, hits);
    rdm("ovf halt", `SAC_OFS_STAT, 32'h0000_0409, 32'h0000_0409);
    chk("oe off", 32'h0, {31'h0, o_sdo_oe});
    $display("test overflow done");
  endtask : t_overflow

  task automatic t_underrun();
    cfg(32'h0000_0780);
    codec.run(2'b00, 2, 16'h0505, 16'h0606, 16'h0000, 1'b0, hits);
    chk("zero slots", 32'd4, 32'(hits));
    rdm("und event", `SAC_OFS_STAT, 32'h0000_040A, 32'h0000_000A);
    cfg(32'h0000_0280);
    codec.run(2'b00, 1, 16'h0505, 16'h0606, 16'h0000, 1'b0, hits);
    rdm("und halt", `SAC_OFS_STAT, 32'h0000_040A, 32'h0000_0402);
    chk("oe off", 32'h0, {31'h0, o_sdo_oe});
    $display("test underrun done");
  endtask : t_underrun

  // Stereo spends the word in one slot; mono repeats it in both slots of a frame.
  task automatic t_mono();
    for (int m = 0; m < 2; m++) begin
      cfg(32'h0000_0380 | (m == 1 ? 32'h0000_0008 : 32'h0000_0000));
      wr(`SAC_OFS_TXB, 32'h0000_3C5A);
      codec.run(2'b00, 3, 16'h0707, 16'h0808, 16'h3C5A, 1'b0, hits);
      chk("slots with word", 32'(1 + m), 32'(hits));
    end
    $display("test mono done");
  endtask : t_mono

  // Serial mode ignores the mono and framing fields, so every word pops from the buffer.
  task automatic t_serial();
    logic [15:0] got;
    cfg(32'h0000_030B);
    wr(`SAC_OFS_TXB, 32'h0000_5AC3);
    codec.xfer(16'h1E2D, got);
    chk("serial first out", 32'h0, {16'h0000, got});
    rdm("serial rx", `SAC_OFS_RXB, 32'hFFFF_FFFF, 32'h0000_1E2D);
    codec.xfer(16'h0000, got);
    chk("serial second out", 32'h0000_5AC3, {16'h0000, got});
    chk("serial oe idle", 32'h0, {31'h0, o_sdo_oe});
    $display("test serial done");
  endtask : t_serial

  initial begin
    i_reset = 1'b1;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    i_addr  = 8'h00;
    i_wdata = 32'h0000_0000;
    repeat (4) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    t_regs();
    t_formats();
    t_sext();
    t_events();
    t_overflow();
    t_underrun();
    t_mono();
    t_serial();
    wrap_up();
  end
endmodule : sac_spi_audio_bench
